// ==== rtl/call_add_compare_core.sv ====
/*
 * Execution core for paged call/jump, add, add with carry-in, byte and
 * bit conjunction and compare-branch-unequal.
 * Assumes synchronous program and data memories: a read strobe in one
 * cycle returns its byte in the following cycle; writes take effect at
 * the edge that ends the write strobe cycle.
 */
// Contract
// - Page call: PC plus two, push low-first
// - Call target: PC[15:11], opcode[7:5], byte two
// - Page jump: same target, no stack, no flags
// - Add: sum to acc, carry and half-carry
// - Overflow is carry6 XOR carry7 for adds
// - Add with carry-in includes carry, same flags
// - Adds take register, direct, indirect, immediate
// - Byte conjunction stores AND, flags untouched
// - Read-modify-write reads port output latch
// - Conjunction opcodes 0x58+r, 0x55, 0x52
// - Bit conjunction clears carry on zero bit
// - Inverted variant uses complement, bit unchanged
// - Inverted bit conjunction opcode 0xB0, bit byte
// - Compare-branch: PC plus three, branch if unequal
// - Compare sets carry when first is smaller
// - Compare supports exactly four operand pairings
// - Register compare opcode 0xB8+r, imm, rel
// - Indirect compare opcode 0xB6+i, imm, rel
`default_nettype none

module call_add_compare_core
	import core_ops_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// Program memory
	output logic             codeRe,
	output logic [15:0]      codeAddr,
	input  wire logic [7:0]  codeRdData,
	// Internal data memory, special registers and ports
	output logic             dataRe,
	output logic             dataRmw,
	output logic             dataWe,
	output logic [7:0]       dataAddr,
	output logic [7:0]       dataWrData,
	input  wire logic [7:0]  dataRdData,
	// Register bank select from the status word
	input  wire logic [1:0]  bankSel,
	// Architectural state
	output logic [15:0]      progCounter,
	output logic [7:0]       accumulator,
	output logic [7:0]       stackPointer,
	output flags_t           flags,
	// Status pulses
	output logic             instrDone,
	output logic             unknownOp
);

	////////////////////////////////////////////////////////////////////////
	// Sequencer state and instruction latches

	typedef enum logic [2:0] {
		ST_FETCH, ST_CWAIT, ST_CLAND, ST_DWAIT, ST_DLAND, ST_EXEC, ST_PUSH
	} state_t;

	state_t      state_r;
	logic [1:0]  idx_r;
	logic [7:0]  op_r;
	logic [7:0]  b2_r;
	logic [7:0]  b3_r;
	decode_t     dec_r;
	logic        ptrPhase_r;
	logic [7:0]  memVal_r;
	logic [7:0]  retHi_r;

	// Bytes as they land, before the latches catch them
	logic [7:0]  curOp;
	logic [7:0]  curB2;
	decode_t     curDec;
	logic        lastByte;
	logic [7:0]  firstDataAddr;

	assign curOp    = (idx_r == 2'd0) ? codeRdData : op_r;
	assign curB2    = (idx_r == 2'd1) ? codeRdData : b2_r;
	assign curDec   = (idx_r == 2'd0) ? decodeOp(codeRdData) : dec_r;
	assign lastByte = ({1'b0, idx_r} + 3'd1) >= {1'b0, curDec.len};

	// First data read: register, pointer register, direct or bit byte
	always_comb begin
		case (curDec.mode)
			M_REG:   firstDataAddr = {3'b000, bankSel, curOp[2:0]};
			M_IND:   firstDataAddr = {3'b000, bankSel, 2'b00, curOp[0]};
			M_BIT:   firstDataAddr = curB2[7] ? {curB2[7:3], 3'b000}
				: {BIT_AREA_UPPER, curB2[6:3]};
			default: firstDataAddr = curB2;
		endcase
	end

	// Main sequence: fetch bytes, read operands, execute, push
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r    <= ST_FETCH;
			idx_r      <= 2'd0;
			op_r       <= 8'h00;
			b2_r       <= 8'h00;
			b3_r       <= 8'h00;
			dec_r      <= '{K_NONE, M_NONE, 2'd1};
			ptrPhase_r <= 1'b0;
			memVal_r   <= 8'h00;
		end else begin
			case (state_r)
				ST_FETCH: begin
					idx_r   <= 2'd0;
					state_r <= ST_CWAIT;
				end
				ST_CWAIT: state_r <= ST_CLAND;
				ST_CLAND: begin
					case (idx_r)
						2'd0: begin
							op_r  <= codeRdData;
							dec_r <= curDec;
						end
						2'd1:    b2_r <= codeRdData;
						default: b3_r <= codeRdData;
					endcase
					ptrPhase_r <= (curDec.mode == M_IND);
					if (!lastByte) begin
						idx_r   <= idx_r + 2'd1;
						state_r <= ST_CWAIT;
					end else if (curDec.mode != M_NONE) begin
						state_r <= ST_DWAIT;
					end else begin
						state_r <= ST_EXEC;
					end
				end
				ST_DWAIT: state_r <= ST_DLAND;
				ST_DLAND: begin
					// Pointer landed: go round once more for the target byte
					ptrPhase_r <= 1'b0;
					memVal_r   <= dataRdData;
					state_r    <= ptrPhase_r ? ST_DWAIT : ST_EXEC;
				end
				ST_EXEC: state_r <= (dec_r.kind == K_PAGE_CALL) ? ST_PUSH : ST_FETCH;
				ST_PUSH: state_r <= ST_FETCH;
				default: state_r <= ST_FETCH;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Execute datapath

	logic        carryIn;
	logic [7:0]  srcByte;
	logic [4:0]  sumLow;
	logic [7:0]  sumMid;
	logic [8:0]  sumAll;
	logic [15:0] pcInc;
	logic [15:0] pageTarget;
	logic [15:0] relTarget;
	logic [7:0]  cmpLeft;
	logic [7:0]  cmpRight;
	logic        bitOpnd;
	logic [7:0]  conjOther;

	// Immediate operands come from byte two, except byte three for 0x53; memory ones from the read
	assign srcByte = (dec_r.mode == M_NONE) ? b2_r : memVal_r;
	assign carryIn = (dec_r.kind == K_SUM_CARRY) & flags.carry;
	// sum with nibble and bit-6 carries
	assign sumLow = {1'b0, accumulator[3:0]} + {1'b0, srcByte[3:0]} + {4'h0, carryIn};
	assign sumMid = {1'b0, accumulator[6:0]} + {1'b0, srcByte[6:0]} + {7'h00, carryIn};
	assign sumAll = {1'b0, accumulator} + {1'b0, srcByte} + {8'h00, carryIn};

	assign pcInc = progCounter + {14'h0000, dec_r.len};
	assign pageTarget = {pcInc[15:11], op_r[7:5], b2_r};
	assign relTarget  = pcInc + {{8{b3_r[7]}}, b3_r};

	assign cmpLeft  = (op_r[3] | (op_r[2] & op_r[1])) ? memVal_r : accumulator;
	assign cmpRight = (op_r == OP_CMP_ACC_DIR) ? memVal_r : b2_r;

	assign bitOpnd = (op_r == OP_CONJ_CARRY_INV) ? ~memVal_r[b2_r[2:0]]
		: memVal_r[b2_r[2:0]];
	assign conjOther = (op_r == OP_CONJ_DIR_ACC) ? accumulator : b3_r;

	////////////////////////////////////////////////////////////////////////
	// Program counter

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			progCounter <= PC_RESET;
		end else if (state_r == ST_EXEC) begin
			case (dec_r.kind)
				K_PAGE_CALL, K_PAGE_JUMP: progCounter <= pageTarget;
				K_CMP_BRANCH: progCounter <= (cmpLeft != cmpRight) ? relTarget : pcInc;
				default:      progCounter <= pcInc;
			endcase
		end
	end

	// Return address high byte kept for the second push
	always_ff @(posedge ref_clk) begin
		if (rst)
			retHi_r <= 8'h00;
		else if (state_r == ST_EXEC)
			retHi_r <= pcInc[15:8];
	end

	////////////////////////////////////////////////////////////////////////
	// Accumulator and flags

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			accumulator <= ACC_RESET;
		end else if (state_r == ST_EXEC) begin
			case (dec_r.kind)
				K_SUM, K_SUM_CARRY: accumulator <= sumAll[7:0];
				K_CONJ_ACC:         accumulator <= accumulator & srcByte;
				default:            accumulator <= accumulator;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags <= '{1'b0, 1'b0, 1'b0};
		end else if (state_r == ST_EXEC) begin
			case (dec_r.kind)
				K_SUM, K_SUM_CARRY: begin
					flags.carry     <= sumAll[8];
					flags.halfCarry <= sumLow[4];
					flags.signedWrap <= sumAll[8] ^ sumMid[7];
				end
				K_CONJ_CARRY: begin
					if (!bitOpnd)
						flags.carry <= 1'b0;
				end
				K_CMP_BRANCH: flags.carry <= (cmpLeft < cmpRight);
				default:      flags <= flags;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stack pointer

	always_ff @(posedge ref_clk) begin
		if (rst)
			stackPointer <= SP_RESET;
		else if ((state_r == ST_EXEC && dec_r.kind == K_PAGE_CALL) || state_r == ST_PUSH)
			stackPointer <= stackPointer + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// Program memory port; strobes are one-cycle registered pulses

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			codeRe   <= 1'b0;
			codeAddr <= PC_RESET;
		end else begin
			codeRe <= 1'b0;
			if (state_r == ST_FETCH) begin
				codeRe   <= 1'b1;
				codeAddr <= progCounter;
			end else if (state_r == ST_CLAND && !lastByte) begin
				codeRe   <= 1'b1;
				codeAddr <= progCounter + {14'h0000, idx_r + 2'd1};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data memory port

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dataRe     <= 1'b0;
			dataRmw    <= 1'b0;
			dataWe     <= 1'b0;
			dataAddr   <= 8'h00;
			dataWrData <= 8'h00;
		end else begin
			dataRe  <= 1'b0;
			dataRmw <= 1'b0;
			dataWe  <= 1'b0;
			if (state_r == ST_CLAND && lastByte && curDec.mode != M_NONE) begin
				dataRe   <= 1'b1;
				dataAddr <= firstDataAddr;
				dataRmw  <= (curDec.kind == K_CONJ_DIR);
			end else if (state_r == ST_DLAND && ptrPhase_r) begin
				dataRe   <= 1'b1;
				dataAddr <= dataRdData;
			end else if (state_r == ST_EXEC && dec_r.kind == K_CONJ_DIR) begin
				dataWe     <= 1'b1;
				dataAddr   <= b2_r;
				dataWrData <= memVal_r & conjOther;
			end else if (state_r == ST_EXEC && dec_r.kind == K_PAGE_CALL) begin
				dataWe     <= 1'b1;
				dataAddr   <= stackPointer + 8'h01;
				dataWrData <= pcInc[7:0];
			end else if (state_r == ST_PUSH) begin
				dataWe     <= 1'b1;
				dataAddr   <= stackPointer + 8'h01;
				dataWrData <= retHi_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Completion and unknown-opcode pulses

	// Unknown opcodes are stepped over as one-byte no-ops
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			instrDone <= 1'b0;
			unknownOp <= 1'b0;
		end else begin
			instrDone <= (state_r == ST_EXEC && dec_r.kind != K_PAGE_CALL)
				|| state_r == ST_PUSH;
			unknownOp <= (state_r == ST_EXEC && dec_r.kind == K_NONE);
		end
	end

endmodule

`default_nettype wire

// ==== rtl/core_ops_pkg.sv ====
/*
 * Shared constants, opcode layout, decode types and the opcode decoder
 * for the call / add / logical-and / compare-branch execution core.
 * Assumes a single clock domain; used by the core and by the bench.
 */
`default_nettype none

package core_ops_pkg;

	// Paged transfer opcode tails; bits 7-5 carry target bits 10-8
	localparam logic [4:0] PAGE_CALL_TAIL = 5'h11;
	localparam logic [4:0] PAGE_JUMP_TAIL = 5'h01;

	// Families keyed by the high nibble of the opcode
	localparam logic [3:0] FAM_SUM       = 4'h2;
	localparam logic [3:0] FAM_SUM_CARRY = 4'h3;
	localparam logic [3:0] FAM_CONJ      = 4'h5;
	localparam logic [3:0] FAM_CMP       = 4'hB;

	// Low three bits inside a family when bit 3 is clear
	localparam logic [2:0] LOW_IMM     = 3'h4;
	localparam logic [2:0] LOW_DIR     = 3'h5;
	localparam logic [2:0] LOW_DIR_ACC = 3'h2;
	localparam logic [2:0] LOW_DIR_IMM = 3'h3;

	// Single-byte opcodes
	localparam logic [7:0] OP_CONJ_CARRY     = 8'h82;
	localparam logic [7:0] OP_CONJ_CARRY_INV = 8'hB0;
	localparam logic [7:0] OP_CMP_ACC_IMM    = 8'hB4;
	localparam logic [7:0] OP_CMP_ACC_DIR    = 8'hB5;
	localparam logic [7:0] OP_CONJ_DIR_ACC   = 8'h52;

	// Reset values and the bit-addressable area base (upper nibble)
	localparam logic [15:0] PC_RESET       = 16'h0000;
	localparam logic [7:0]  SP_RESET       = 8'h07;
	localparam logic [7:0]  ACC_RESET      = 8'h00;
	localparam logic [3:0]  BIT_AREA_UPPER = 4'h2;

	typedef enum logic [3:0] {
		K_NONE, K_PAGE_CALL, K_PAGE_JUMP, K_SUM, K_SUM_CARRY,
		K_CONJ_ACC, K_CONJ_DIR, K_CONJ_CARRY, K_CMP_BRANCH
	} op_kind_t;

	typedef enum logic [2:0] {M_NONE, M_REG, M_DIR, M_IND, M_BIT} opnd_mode_t;

	typedef struct packed {
		op_kind_t   kind;
		opnd_mode_t mode;
		logic [1:0] len;
	} decode_t;

	typedef struct packed {
		logic carry;
		logic halfCarry;
		logic signedWrap;
	} flags_t;

	// Opcode to kind, memory operand mode and instruction length
	function automatic decode_t decodeOp(input logic [7:0] op);
		decode_t d;
		d.kind = K_NONE;
		d.mode = M_NONE;
		d.len  = 2'd1;
		if (op[4:0] == PAGE_CALL_TAIL) begin
			d.kind = K_PAGE_CALL;
			d.len  = 2'd2;
		end else if (op[4:0] == PAGE_JUMP_TAIL) begin
			d.kind = K_PAGE_JUMP;
			d.len  = 2'd2;
		end else if (op == OP_CONJ_CARRY || op == OP_CONJ_CARRY_INV) begin
			d.kind = K_CONJ_CARRY;
			d.mode = M_BIT;
			d.len  = 2'd2;
		end else if (op[7:4] == FAM_CMP && op[3:2] != 2'b00) begin
			d.kind = K_CMP_BRANCH;
			d.len  = 2'd3;
			if (op[3])
				d.mode = M_REG;
			else if (op[2:1] == 2'b11)
				d.mode = M_IND;
			else if (op == OP_CMP_ACC_DIR)
				d.mode = M_DIR;
		end else if (op[7:4] == FAM_SUM || op[7:4] == FAM_SUM_CARRY
				|| op[7:4] == FAM_CONJ) begin
			d.kind = (op[7:4] == FAM_SUM) ? K_SUM
				: (op[7:4] == FAM_SUM_CARRY) ? K_SUM_CARRY : K_CONJ_ACC;
			if (op[3]) begin
				d.mode = M_REG;
			end else if (op[2:0] == LOW_IMM) begin
				d.len = 2'd2;
			end else if (op[2:0] == LOW_DIR) begin
				d.mode = M_DIR;
				d.len  = 2'd2;
			end else if (op[2:1] == 2'b11) begin
				d.mode = M_IND;
			end else if (op[7:4] == FAM_CONJ && op[2:1] == 2'b01) begin
				d.kind = K_CONJ_DIR;
				d.mode = M_DIR;
				d.len  = (op[2:0] == LOW_DIR_IMM) ? 2'd3 : 2'd2;
			end else begin
				d.kind = K_NONE;
			end
		end
		return d;
	endfunction

endpackage

`default_nettype wire

// ==== bench/core_ops_checker_assertions.sv ====
/*
 * Port-level assertions for the call / add / compare execution core.
 * Assumes it is bound to the core's top module and runs on its one clock.
 */
`default_nettype none

module core_ops_checker
	import core_ops_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// Program port
	input wire logic        codeRe,
	input wire logic [15:0] codeAddr,
	input wire logic [7:0]  codeRdData,
	// Data port
	input wire logic        dataRe,
	input wire logic        dataRmw,
	input wire logic        dataWe,
	input wire logic [7:0]  dataAddr,
	input wire logic [7:0]  dataWrData,
	input wire logic [7:0]  dataRdData,
	input wire logic [1:0]  bankSel,
	// State and status
	input wire logic [15:0] progCounter,
	input wire logic [7:0]  accumulator,
	input wire logic [7:0]  stackPointer,
	input wire flags_t      flags,
	input wire logic        instrDone,
	input wire logic        unknownOp
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////
	logic       pend_r;
	logic       land_r;
	logic [7:0] rmwAddr_r;
	logic [7:0] rmwData_r;

	// Remember the operand of a read-modify-write until it is written back
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pend_r <= 1'b0;
			land_r <= 1'b0;
		end else begin
			land_r <= dataRe && dataRmw;
			if (dataRe && dataRmw)
				pend_r <= 1'b1;
			else if (dataWe)
				pend_r <= 1'b0;
		end
	end

	// Address and data need no reset: only read while pend_r is set
	always_ff @(posedge ref_clk) begin
		if (dataRe && dataRmw)
			rmwAddr_r <= dataAddr;
		if (land_r)
			rmwData_r <= dataRdData;
	end

	////////////////////////////////////////////////////////////////////////////
	// Port-level properties; PC, stack pointer and accumulator reset values come from the shared constants, flags from a literal zero
	a_reset_state: assert property (disable iff (1'b0) rst |=> progCounter == PC_RESET
		&& stackPointer == SP_RESET && accumulator == ACC_RESET && flags == 3'h0 && !dataWe)
		else $error("state not cleared by reset");
	a_code_gap: assert property (codeRe |=> !codeRe)
		else $error("program strobes back to back");
	a_sp_step: assert property ($changed(stackPointer) |->
		stackPointer == $past(stackPointer) + 8'h01) else $error("stack pointer jump");
	a_push_order: assert property (dataWe ##1 dataWe |->
		dataAddr == stackPointer && $past(dataAddr) == dataAddr - 8'h01)
		else $error("push address wrong");
	a_push_two: assert property (dataWe ##1 dataWe |=> !dataWe)
		else $error("more than two pushes");
	a_call_page: assert property (dataWe ##1 dataWe |->
		progCounter[15:11] == dataWrData[7:3]) else $error("call left its 2K block");
	a_state_done: assert property (($changed(accumulator) || $changed(flags))
		|-> instrDone) else $error("state changed outside completion");
	a_rmw_read: assert property (dataRmw |-> dataRe && !dataWe)
		else $error("stray modify flag");
	a_rmw_back: assert property (dataRe && dataRmw |-> ##[2:4] dataWe)
		else $error("no write-back");
	a_rmw_value: assert property (pend_r && dataWe |->
		dataAddr == rmwAddr_r && (dataWrData & ~rmwData_r) == 8'h00)
		else $error("write-back not a masked copy");
endmodule

`default_nettype wire

// ==== bench/core_mem_model.sv ====
/*
 * Program memory and data RAM facing the core, with one output port.
 * Assumes the core's one-cycle strobe/answer contract; no wait states.
 */
`default_nettype none

module core_mem_model (
	// Clock
	input wire logic        ref_clk,
	// Program port
	input wire logic        codeRe,
	input wire logic [15:0] codeAddr,
	output var logic [7:0]  codeRdData,
	// Data port
	input wire logic        dataRe,
	input wire logic        dataRmw,
	input wire logic        dataWe,
	input wire logic [7:0]  dataAddr,
	input wire logic [7:0]  dataWrData,
	output var logic [7:0]  dataRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	parameter logic [7:0] PORT_ADDR = 8'h90;
	parameter logic [7:0] PORT_PINS = 8'h5A;
	logic [7:0] code [0:4095];
	logic [7:0] ram [0:255];

	////////////////////////////////////////////////////////////////////////////
	// Outside the answer cycle the bytes flip, so stale data never matches
	initial codeRdData = 8'h00;
	always @(posedge ref_clk) begin
		if (codeRe)
			codeRdData <= code[codeAddr[11:0]];
		else
			codeRdData <= ~codeRdData;
	end

	// Port reads give the pins, except the modify read, which gets the latch
	initial dataRdData = 8'h00;
	always @(posedge ref_clk) begin
		if (dataWe)
			ram[dataAddr] <= dataWrData;
		if (dataRe)
			dataRdData <= (dataAddr == PORT_ADDR && !dataRmw) ? PORT_PINS : ram[dataAddr];
		else
			dataRdData <= ~dataRdData;
	end
endmodule

`default_nettype wire

// ==== bench/call_add_compare_core_tb_top.sv ====
/*
 * Self-checking bench for the execution core: short programs per scenario.
 * Assumes the memory model answers every strobe in the next cycle.
 */
`default_nettype none

module call_add_compare_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import core_ops_pkg::*;
	logic        ref_clk, rst, codeRe, dataRe, dataRmw, dataWe, instrDone, unknownOp;
	logic [15:0] codeAddr, progCounter;
	logic [7:0]  codeRdData, dataAddr, dataWrData, dataRdData, accumulator, stackPointer;
	logic [1:0]  bankSel;
	flags_t      flags;
	int          mismatches, nCompared;

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	call_add_compare_core i_dut (.ref_clk(ref_clk), .rst(rst), .codeRe(codeRe),
		.codeAddr(codeAddr), .codeRdData(codeRdData), .dataRe(dataRe), .dataRmw(dataRmw),
		.dataWe(dataWe), .dataAddr(dataAddr), .dataWrData(dataWrData),
		.dataRdData(dataRdData), .bankSel(bankSel), .progCounter(progCounter),
		.accumulator(accumulator), .stackPointer(stackPointer), .flags(flags),
		.instrDone(instrDone), .unknownOp(unknownOp));
	core_mem_model i_mem (.ref_clk(ref_clk), .codeRe(codeRe), .codeAddr(codeAddr),
		.codeRdData(codeRdData), .dataRe(dataRe), .dataRmw(dataRmw), .dataWe(dataWe),
		.dataAddr(dataAddr), .dataWrData(dataWrData), .dataRdData(dataRdData));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Hold reset and clear memories so each program starts clean
	task automatic hold(input logic [1:0] bank);
		@(negedge ref_clk);
		rst = 1'b1;
		bankSel = bank;
		for (int a = 0; a < 4096; a++) i_mem.code[a] = 8'h00;
		for (int a = 0; a < 256; a++) i_mem.ram[a] = 8'h00;
	endtask

	task automatic go;
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
	endtask

	task automatic put(input int a, input logic [7:0] q[$]);
		foreach (q[i]) i_mem.code[a + i] = q[i];
	endtask

	// Wait for completion, bounded, then compare the architectural state
	task automatic step(input logic [15:0] pc, input logic [7:0] acc, input logic [2:0] fl);
		int k;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
		end while (instrDone !== 1'b1 && k < 40);
		check({15'h0, instrDone}, 16'h0001);
		check(progCounter, pc);
		check({8'h00, accumulator}, {8'h00, acc});
		check({13'h0, flags}, {13'h0, fl});
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic sc_add;
		hold(2'b00);
		put(0, '{8'h24, 8'hC3, 8'h28, 8'h38, 8'h25, 8'h40, 8'h37, 8'h34, 8'h80, 8'h26});
		i_mem.ram[8'h00] = 8'hAA;
		i_mem.ram[8'h01] = 8'h50;
		i_mem.ram[8'h40] = 8'h01;
		i_mem.ram[8'h50] = 8'h67;
		i_mem.ram[8'hAA] = 8'hFF;
		go();
		step(16'h0002, 8'hC3, 3'b000);
		step(16'h0003, 8'h6D, 3'b101);
		step(16'h0004, 8'h18, 3'b110);
		step(16'h0006, 8'h19, 3'b000);
		step(16'h0007, 8'h80, 3'b011);
		step(16'h0009, 8'h00, 3'b101);
		step(16'h000A, 8'hFF, 3'b000);
	endtask

	// The trailing immediate form also lets the last write-back land
	task automatic sc_conj;
		hold(2'b00);
		put(0, '{8'h24, 8'hFF, 8'h24, 8'hC4, 8'h58, 8'h55, 8'h40, 8'h52, 8'h90});
		put(9, '{8'h53, 8'h41, 8'hF0, 8'h54, 8'hFE});
		i_mem.ram[8'h00] = 8'h55;
		i_mem.ram[8'h40] = 8'h0F;
		i_mem.ram[8'h41] = 8'h3C;
		i_mem.ram[8'h90] = 8'hF3;
		go();
		step(16'h0002, 8'hFF, 3'b000);
		step(16'h0004, 8'hC3, 3'b110);
		step(16'h0005, 8'h41, 3'b110);
		step(16'h0007, 8'h01, 3'b110);
		step(16'h0009, 8'h01, 3'b110);
		step(16'h000C, 8'h01, 3'b110);
		step(16'h000E, 8'h00, 3'b110);
		check({8'h00, i_mem.ram[8'h90]}, 16'h0001);
		check({8'h00, i_mem.ram[8'h41]}, 16'h0030);
	endtask

	task automatic sc_bit;
		hold(2'b00);
		put(0, '{8'h24, 8'hFF, 8'h24, 8'hC4, 8'h82, 8'h08, 8'h82, 8'h09, 8'h24, 8'hFF});
		put(10, '{8'hB0, 8'h09, 8'hB0, 8'h08});
		i_mem.ram[8'h21] = 8'h01;
		go();
		step(16'h0002, 8'hFF, 3'b000);
		step(16'h0004, 8'hC3, 3'b110);
		step(16'h0006, 8'hC3, 3'b110);
		step(16'h0008, 8'hC3, 3'b010);
		step(16'h000A, 8'hC2, 3'b110);
		step(16'h000C, 8'hC2, 3'b110);
		step(16'h000E, 8'hC2, 3'b010);
		check({8'h00, i_mem.ram[8'h21]}, 16'h0001);
	endtask

	// Bank one, and a negative displacement that wraps below address zero
	task automatic sc_cmp;
		hold(2'b01);
		put(0, '{8'hB4, 8'h34, 8'h02, 8'h00, 8'h00, 8'hB8, 8'h00, 8'hF0});
		put(8, '{8'hB6, 8'h10, 8'h03, 8'h00, 8'h00, 8'h00, 8'hB5, 8'h40, 8'h80});
		put(12'hF91, '{8'hB9, 8'h7F, 8'h00});
		i_mem.ram[8'h09] = 8'h80;
		i_mem.ram[8'h40] = 8'h0F;
		go();
		step(16'h0005, 8'h00, 3'b100);
		step(16'h0008, 8'h00, 3'b000);
		step(16'h000E, 8'h00, 3'b100);
		step(16'hFF91, 8'h00, 3'b100);
		step(16'hFF94, 8'h00, 3'b000);
		check({8'h00, i_mem.ram[8'h09]}, 16'h0080);
	endtask

	task automatic sc_call;
		hold(2'b00);
		put(0, '{8'h24, 8'hFF, 8'h24, 8'hC4, 8'h21, 8'h23});
		put(16'h0123, '{8'h71, 8'h45});
		go();
		step(16'h0002, 8'hFF, 3'b000);
		step(16'h0004, 8'hC3, 3'b110);
		step(16'h0123, 8'hC3, 3'b110);
		step(16'h0345, 8'hC3, 3'b110);
		check({15'h0, unknownOp}, 16'h0000);
		check({8'h00, stackPointer}, 16'h0009);
		// Second push strobe stands with completion; it lands one edge later
		@(negedge ref_clk);
		check({i_mem.ram[8'h09], i_mem.ram[8'h08]}, 16'h0125);
		// Opcode 0x00 is outside the group: a one-byte no-op
		step(16'h0346, 8'hC3, 3'b110);
		check({15'h0, unknownOp}, 16'h0001);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("mismatches %0d compared %0d", mismatches, nCompared);
		if (mismatches == 0 && nCompared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		bankSel = 2'b00;
		mismatches = 0;
		nCompared = 0;
		sc_add();
		sc_conj();
		sc_bit();
		sc_cmp();
		sc_call();
		wrap_up();
	end

	// The whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		wrap_up();
	end
endmodule

bind call_add_compare_core core_ops_checker i_chk (.ref_clk(ref_clk), .rst(rst),
	.codeRe(codeRe), .codeAddr(codeAddr), .codeRdData(codeRdData), .dataRe(dataRe),
	.dataRmw(dataRmw), .dataWe(dataWe), .dataAddr(dataAddr), .dataWrData(dataWrData),
	.dataRdData(dataRdData), .bankSel(bankSel), .progCounter(progCounter),
	.accumulator(accumulator), .stackPointer(stackPointer), .flags(flags),
	.instrDone(instrDone), .unknownOp(unknownOp));

`default_nettype wire
